// [bench/test_lvsc_top.sv]
// Self-checking bench for the low-voltage monitor and standby control
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_lvsc_top
  import lvsc_pkg::*;
;
  // One bus access with its expected read answer
  typedef struct packed {
    logic        w;
    logic [15:0] a;
    logic [7:0]  d;
    logic [3:0]  be;
    logic [7:0]  e;
    logic [1:0]  r;
  } lvsc_row_t;

  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [15:0]       adr = 16'h0000;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [31:0]       wdat = 32'h0;
  logic [3:0]        be = 4'hf;
  logic [31:0]       rdat;
  logic              wreq;
  logic [1:0]        resp;
  lvsc_cmp_t         cmp = '0;
  logic              sleep = 1'b0;
  logic              irq, lvrst, stby, osc;
  logic [2:0]        act;
  logic [7:0]        rdat_s;
  logic [1:0]        resp_s;
  logic              exp_b;
  int                err_count = 0;
  int                n_tests = 0;
  int                cyc = 0;

  // Register map walk: reset values, readback, refused writes
  localparam lvsc_row_t rows [14] = '{
    '{1'b0, LVSC_CTRL_IDX, 8'h00, 4'hf, 8'h00, 2'h0},
    '{1'b0, LVSC_STAT_IDX, 8'h00, 4'hf, 8'h00, 2'h0},
    '{1'b0, LVSC_SYS1_IDX, 8'h00, 4'hf, 8'h00, 2'h0},
    '{1'b0, LVSC_SYS2_IDX, 8'h00, 4'hf, 8'h00, 2'h0},
    '{1'b1, LVSC_CTRL_IDX, 8'h8f, 4'hf, 8'h00, 2'h0},
    '{1'b0, LVSC_CTRL_IDX, 8'h00, 4'hf, 8'h8f, 2'h0},
    '{1'b1, LVSC_SYS1_IDX, 8'hc0, 4'hf, 8'h00, 2'h0},
    '{1'b0, LVSC_SYS1_IDX, 8'h00, 4'hf, 8'hc0, 2'h0},
    '{1'b1, LVSC_SYS2_IDX, 8'h3c, 4'hf, 8'h00, 2'h0},
    '{1'b1, LVSC_SYS2_IDX, 8'h00, 4'he, 8'h00, 2'h0},
    '{1'b0, LVSC_SYS2_IDX, 8'h00, 4'hf, 8'h3c, 2'h0},
    '{1'b1, 16'hf7f0, 8'hff, 4'hf, 8'h00, 2'h0},
    '{1'b0, LVSC_SYS1_IDX, 8'h00, 4'hf, 8'hc0, 2'h0},
    '{1'b0, 16'h0000, 8'h00, 4'hf, 8'h00, 2'h3}};
  localparam logic [3:0] cv [3] = '{4'h0, 4'h1, 4'h3};

  lvsc_top dut (
    .REF_CLK_I        (clk),
    .RSTN_I           (rst_n),
    .AVS_ADDRESS_I    (adr),
    .AVS_READ_I       (rd),
    .AVS_WRITE_I      (wr),
    .AVS_WRITEDATA_I  (wdat),
    .AVS_BYTEENABLE_I (be),
    .AVS_READDATA_O   (rdat),
    .AVS_WAITREQUEST_O(wreq),
    .AVS_RESPONSE_O   (resp),
    .CMP_I            (cmp),
    .SLEEP_I          (sleep),
    .LV_IRQ_O         (irq),
    .LV_RESET_O       (lvrst),
    .STANDBY_O        (stby),
    .OSC_CLK_SEL_O    (osc),
    .ACT_CLK_SEL_O    (act)
  );

  // 25 MHz reference clock
  always #20 clk = ~clk;

  // Hang guard; a normal run needs about 2500 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Request held until waitrequest is sampled low, then released;
  // only the hang guard ends a wait that never gets an answer
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [7:0] d, input logic [3:0] b);
    @(posedge clk);
    adr <= a;
    wdat <= {24'h0, d};
    be <= b;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    rdat_s = rdat[7:0];
    resp_s = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hf);
    `CHK(rdat_s, e)
  endtask

  // Comparator levels change, then settle for a few cycles
  task automatic set_cmp(input logic [3:0] v);
    @(posedge clk);
    cmp <= lvsc_cmp_t'(v);
    tick(3);
  endtask

  task automatic sleep_pulse;
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    sleep <= 1'b0;
    tick(2);
  endtask

  task automatic do_reset(input int n);
    @(posedge clk);
    rst_n <= 1'b0;
    tick(n);
    rst_n <= 1'b1;
    tick(1);
  endtask

  // Main sequence
  initial begin
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    `CHK({osc, stby, irq, lvrst}, 4'h8)
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d, rows[i].be);
      if (!rows[i].w) begin
        `CHK(rdat_s, rows[i].e)
        `CHK(resp_s, rows[i].r)
      end
    end
    tick(2);
    `CHK({osc, act}, 4'h7)
    wr_reg(LVSC_SYS2_IDX, 8'h0c);
    tick(2);
    `CHK({osc, act}, 4'hb)
    // Drop flag sticks after the comparator falls back
    wr_reg(LVSC_CTRL_IDX, 8'h82);
    set_cmp(4'h8);
    chk_rd(LVSC_STAT_IDX, 8'h02);
    set_cmp(4'h0);
    chk_rd(LVSC_STAT_IDX, 8'h02);
    `CHK(irq, 1'b1)
    wr_reg(LVSC_CTRL_IDX, 8'h80);
    tick(2);
    `CHK(irq, 1'b0)
    wr_reg(LVSC_STAT_IDX, 8'h01);
    chk_rd(LVSC_STAT_IDX, 8'h00);
    // Rise after drop, with and without the rise enable
    wr_reg(LVSC_CTRL_IDX, 8'h81);
    set_cmp(4'h8);
    set_cmp(4'h4);
    chk_rd(LVSC_STAT_IDX, 8'h03);
    `CHK(irq, 1'b1)
    wr_reg(LVSC_STAT_IDX, 8'h00);
    wr_reg(LVSC_CTRL_IDX, 8'h80);
    set_cmp(4'h8);
    set_cmp(4'h4);
    chk_rd(LVSC_STAT_IDX, 8'h02);
    `CHK(irq, 1'b0)
    // A reset-level dip between drop and rise cancels the rise
    wr_reg(LVSC_STAT_IDX, 8'h00);
    wr_reg(LVSC_CTRL_IDX, 8'h81);
    set_cmp(4'h8);
    set_cmp(4'ha);
    set_cmp(4'h4);
    chk_rd(LVSC_STAT_IDX, 8'h02);
    // Monitor off: no flags, no request
    wr_reg(LVSC_STAT_IDX, 8'h00);
    wr_reg(LVSC_CTRL_IDX, 8'h03);
    set_cmp(4'h8);
    set_cmp(4'h4);
    chk_rd(LVSC_STAT_IDX, 8'h00);
    `CHK(irq, 1'b0)
    // Reset level select and reset enable, every combination
    for (int s = 0; s < 2; s++)
      for (int e = 0; e < 2; e++)
        for (int c = 0; c < 3; c++) begin
          wr_reg(LVSC_CTRL_IDX, 8'h80 | 8'(s << 3) | 8'(e << 2));
          set_cmp(cv[c]);
          exp_b = (e == 1) && ((s == 1) ? cv[c][0] : cv[c][1]);
          `CHK(lvrst, exp_b)
        end
    // Standby: refused with direct transfer or without standby bit
    set_cmp(4'h0);
    wr_reg(LVSC_CTRL_IDX, 8'h81);
    wr_reg(LVSC_SYS1_IDX, 8'h90);
    wr_reg(LVSC_SYS2_IDX, 8'h20);
    sleep_pulse();
    `CHK(stby, 1'b0)
    wr_reg(LVSC_SYS1_IDX, 8'h10);
    wr_reg(LVSC_SYS2_IDX, 8'h00);
    sleep_pulse();
    `CHK(stby, 1'b0)
    wr_reg(LVSC_SYS1_IDX, 8'h90);
    sleep_pulse();
    `CHK(stby, 1'b1)
    tick(1100);
    `CHK(stby, 1'b1)
    set_cmp(4'h8);
    set_cmp(4'h4);
    `CHK(stby, 1'b0)
    // Long wait select: still waiting well past the short period, so a
    // rise event cannot wake it yet
    wr_reg(LVSC_SYS1_IDX, 8'hc0);
    sleep_pulse();
    `CHK(stby, 1'b1)
    tick(1100);
    set_cmp(4'h8);
    set_cmp(4'h4);
    `CHK(stby, 1'b1)
    // Second reset in mid-run restores defaults
    do_reset(2);
    chk_rd(LVSC_CTRL_IDX, 8'h00);
    `CHK({osc, stby}, 2'h2)
    end_sim();
  end
endmodule

// [src/lvsc_detect.sv]
// Low-voltage detector: drop/rise tracking and reset request
`timescale 1ns/1ps
module lvsc_detect
  import lvsc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       mon_en,
  input  wire logic       rise_ie,
  input  wire logic       rst_en,
  input  wire logic       rst_sel,
  // Comparators
  input  wire lvsc_cmp_t  cmp,
  // Events out
  output logic            drop_evt,
  output logic            rise_evt,
  output logic            lv_reset
);

  logic armed;
  logic below;
  logic reset_hit;

  // Threshold choice between the two reset levels
  assign reset_hit = rst_sel ? cmp.reset_high : cmp.reset_low;

  // Armed by a drop, disarmed by rise or by the low reset level (reset_low)
  always_ff @(posedge clk) begin
    if (!rst_n || !mon_en) begin
      armed <= 1'b0;
      below <= 1'b0;
    end else begin
      below <= cmp.drop;
      if (cmp.reset_low)
        armed <= 1'b0;
      else if (cmp.drop)
        armed <= 1'b1;
      else if (cmp.rise)
        armed <= 1'b0;
    end
  end

  // Drop on entering the low band; rise only with its enable set
  assign drop_evt = mon_en && cmp.drop && !below;
  assign rise_evt = mon_en && rise_ie && armed && cmp.rise
                    && !cmp.reset_low && !cmp.drop;
  // Reset only while enabled
  assign lv_reset = mon_en && rst_en && reset_hit;

endmodule

// [src/lvsc_pkg.sv]
// Package: register map, field positions and constants for the standby control
package lvsc_pkg;

  // Register offsets (byte addresses; the control offset is our own pick)
  localparam logic [15:0] LVSC_CTRL_IDX   = 16'hf730;
  localparam logic [15:0] LVSC_STAT_IDX   = 16'hf731;
  localparam logic [15:0] LVSC_SYS1_IDX   = 16'hfff0;
  localparam logic [15:0] LVSC_SYS2_IDX   = 16'hfff1;
  localparam logic [15:0] LVSC_SYS1_PRINT = 16'hfff0;
  localparam logic [15:0] LVSC_SYS2_PRINT = 16'hfff1;

  // Bus address width (word address = index)
  localparam int LVSC_AW = 16;

  // Control register fields
  localparam int CTRL_MON_EN   = 7;
  localparam int CTRL_RST_SEL  = 3;
  localparam int CTRL_RST_EN   = 2;
  localparam int CTRL_DROP_IE  = 1;
  localparam int CTRL_RISE_IE  = 0;

  // Status register fields
  localparam int STAT_DROP = 1;
  localparam int STAT_RISE = 0;

  // System control one fields
  localparam int SYS1_SOFTWARE_STANDBY   = 7;
  localparam int SYS1_STS_LO = 4;

  // System control two fields
  localparam int SYS2_DIRECT_TRANSFER_FLAG  = 5;
  localparam int SYS2_MA_LO = 2;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] SYS1_RESET = 8'h00;
  localparam logic [7:0] SYS2_RESET = 8'h00;

  // Standby wait select code for the long period and its count
  localparam logic [2:0]  STS_LONG       = 3'h4;
  localparam int          WAIT_LONG      = 131072;
  localparam logic [17:0] WAIT_LONG_CYC  = 18'(WAIT_LONG);
  localparam logic [17:0] WAIT_SHORT_CYC = 18'h00400;

  // Comparator levels in millivolts
  localparam int DROP_MV       = 3700;
  localparam int RISE_MV       = 4000;
  localparam int RESET_LOW_MV  = 2300;
  localparam int RESET_HIGH_MV = 3600;

  // Power modes
  typedef enum logic [1:0] {
    LVSC_ACTIVE,
    LVSC_STANDBY_WAIT,
    LVSC_STANDBY
  } lvsc_mode_t;

  // Comparator event bundle
  typedef struct packed {
    logic drop;
    logic rise;
    logic reset_low;
    logic reset_high;
  } lvsc_cmp_t;

endpackage

// [src/lvsc_top.sv]
// Top: low-voltage monitor and standby control behind an Avalon-MM slave
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module lvsc_top
  import lvsc_pkg::*;
(
  // Clock and reset
  input  wire logic               REF_CLK_I,
  input  wire logic               RSTN_I,
  // Avalon-MM slave
  input  wire logic [LVSC_AW-1:0] AVS_ADDRESS_I,
  input  wire logic               AVS_READ_I,
  input  wire logic               AVS_WRITE_I,
  input  wire logic [31:0]        AVS_WRITEDATA_I,
  input  wire logic [3:0]         AVS_BYTEENABLE_I,
  output logic [31:0]             AVS_READDATA_O,
  output logic                    AVS_WAITREQUEST_O,
  output logic [1:0]              AVS_RESPONSE_O,
  // Supply comparators
  input  wire lvsc_cmp_t          CMP_I,
  // CPU sleep instruction strobe
  input  wire logic               SLEEP_I,
  // Outputs
  output logic                    LV_IRQ_O,
  output logic                    LV_RESET_O,
  output logic                    STANDBY_O,
  output logic                    OSC_CLK_SEL_O,
  output logic [2:0]              ACT_CLK_SEL_O
);

  logic [7:0]  voltage_monitor_control;
  logic [7:0]  voltage_monitor_status;
  logic [7:0]  system_control_one;
  logic [7:0]  system_control_two;
  logic        ack;
  logic        drop_evt;
  logic        rise_evt;
  logic        lv_reset;
  logic        wr_hit;
  logic        mapped;
  logic [7:0]  rd_byte;
  logic [17:0] wait_cnt;
  logic [17:0] wait_len;
  lvsc_mode_t  mode;
  lvsc_mode_t  next_mode;

  // One wait cycle per access keeps timing simple
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I)
      ack <= 1'b0;
    else
      ack <= (AVS_READ_I || AVS_WRITE_I) && !ack;
  end
  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack;
  assign wr_hit = AVS_WRITE_I && ack && AVS_BYTEENABLE_I[0];

  assign mapped = AVS_ADDRESS_I == LVSC_CTRL_IDX
               || AVS_ADDRESS_I == LVSC_STAT_IDX
               || AVS_ADDRESS_I == LVSC_SYS1_IDX
               || AVS_ADDRESS_I == LVSC_SYS2_IDX;

  // Read mux
  always_comb begin
    case (AVS_ADDRESS_I)
      LVSC_CTRL_IDX: rd_byte = voltage_monitor_control;
      LVSC_STAT_IDX: rd_byte = voltage_monitor_status;
      LVSC_SYS1_IDX: rd_byte = system_control_one;
      LVSC_SYS2_IDX: rd_byte = system_control_two;
      default:       rd_byte = 8'h00;
    endcase
  end

  // Read data and response registered at the acknowledging edge
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      AVS_READDATA_O <= 32'h0000_0000;
      AVS_RESPONSE_O <= 2'h0;
    end else if ((AVS_READ_I || AVS_WRITE_I) && !ack) begin
      AVS_READDATA_O <= {24'h000000, rd_byte};
      AVS_RESPONSE_O <= mapped ? 2'h0 : 2'h3;
    end
  end

  // Control and system registers
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      voltage_monitor_control <= CTRL_RESET;
      system_control_one      <= SYS1_RESET;
      system_control_two      <= SYS2_RESET;
    end else if (wr_hit) begin
      if (AVS_ADDRESS_I == LVSC_CTRL_IDX)
        voltage_monitor_control <= AVS_WRITEDATA_I[7:0];
      if (AVS_ADDRESS_I == LVSC_SYS1_IDX)
        system_control_one <= AVS_WRITEDATA_I[7:0];
      if (AVS_ADDRESS_I == LVSC_SYS2_IDX)
        system_control_two <= AVS_WRITEDATA_I[7:0];
    end
  end

  // Detector core; held idle when monitor is off
  lvsc_detect u_detect (
    .clk      (REF_CLK_I),
    .rst_n    (RSTN_I),
    .mon_en   (voltage_monitor_control[CTRL_MON_EN]),
    .rise_ie  (voltage_monitor_control[CTRL_RISE_IE]),
    .rst_en   (voltage_monitor_control[CTRL_RST_EN]),
    .rst_sel  (voltage_monitor_control[CTRL_RST_SEL]),
    .cmp      (CMP_I),
    .drop_evt (drop_evt),
    .rise_evt (rise_evt),
    .lv_reset (lv_reset)
  );

  // Sticky flags: write 0 clears, write 1 keeps; set beats clear
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      voltage_monitor_status <= STAT_RESET;
    end else begin
      voltage_monitor_status[7:2] <= 6'h00;
      if (drop_evt)
        voltage_monitor_status[STAT_DROP] <= 1'b1;
      else if (wr_hit && AVS_ADDRESS_I == LVSC_STAT_IDX
               && !AVS_WRITEDATA_I[STAT_DROP])
        voltage_monitor_status[STAT_DROP] <= 1'b0;
      if (rise_evt)
        voltage_monitor_status[STAT_RISE] <= 1'b1;
      else if (wr_hit && AVS_ADDRESS_I == LVSC_STAT_IDX
               && !AVS_WRITEDATA_I[STAT_RISE])
        voltage_monitor_status[STAT_RISE] <= 1'b0;
    end
  end

  // Interrupt request gated per flag by its enable
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      LV_IRQ_O   <= 1'b0;
      LV_RESET_O <= 1'b0;
    end else begin
      LV_IRQ_O <= (voltage_monitor_status[STAT_DROP]
                   && voltage_monitor_control[CTRL_DROP_IE])
               || (voltage_monitor_status[STAT_RISE]
                   && voltage_monitor_control[CTRL_RISE_IE]);
      LV_RESET_O <= lv_reset;
    end
  end

  // Wait length from the three-bit select field
  always_comb begin
    if (system_control_one[SYS1_STS_LO+:3] == STS_LONG)
      wait_len = WAIT_LONG_CYC;
    else
      wait_len = WAIT_SHORT_CYC;
  end

  // Mode sequencing
  always_comb begin
    next_mode = mode;
    case (mode)
      LVSC_ACTIVE:
        if (SLEEP_I && system_control_one[SYS1_SOFTWARE_STANDBY]
            && !system_control_two[SYS2_DIRECT_TRANSFER_FLAG])
          next_mode = LVSC_STANDBY_WAIT;
      LVSC_STANDBY_WAIT:
        if (wait_cnt == 18'h00001)
          next_mode = LVSC_STANDBY;
      LVSC_STANDBY:
        if (rise_evt)
          next_mode = LVSC_ACTIVE;
      default:
        next_mode = LVSC_ACTIVE;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I)
      mode <= LVSC_ACTIVE;
    else
      mode <= next_mode;
  end

  // Wait counter loads every active cycle, counts down in the wait state
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I)
      wait_cnt <= 18'h00000;
    else if (mode == LVSC_ACTIVE)
      wait_cnt <= wait_len;
    else if (mode == LVSC_STANDBY_WAIT && wait_cnt != 18'h00000)
      wait_cnt <= wait_cnt - 18'h00001;
  end

  // Standby flag and clock selection outputs
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      STANDBY_O     <= 1'b0;
      OSC_CLK_SEL_O <= 1'b1;
      ACT_CLK_SEL_O <= 3'h0;
    end else begin
      STANDBY_O     <= next_mode != LVSC_ACTIVE;
      // Low bits are don't care when the top bit is clear
      OSC_CLK_SEL_O <= !system_control_two[SYS2_MA_LO+2];
      ACT_CLK_SEL_O <= system_control_two[SYS2_MA_LO+:3];
    end
  end

  // Assertions
  property p_rise_irq;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    !voltage_monitor_control[CTRL_RISE_IE]
    && !(voltage_monitor_status[STAT_DROP]
         && voltage_monitor_control[CTRL_DROP_IE]) |=> !LV_IRQ_O;
  endproperty
  a_rise_irq: assert property (p_rise_irq)
    else $error("irq without enable");

  property p_drop_set;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    drop_evt |=> voltage_monitor_status[STAT_DROP];
  endproperty
  a_drop_set: assert property (p_drop_set)
    else $error("drop flag not set");

  property p_rise_en;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    rise_evt |-> voltage_monitor_control[CTRL_RISE_IE];
  endproperty
  a_rise_en: assert property (p_rise_en)
    else $error("rise without enable");

  property p_standby;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    mode == LVSC_ACTIVE && SLEEP_I && system_control_one[SYS1_SOFTWARE_STANDBY]
    && !system_control_two[SYS2_DIRECT_TRANSFER_FLAG] |=> STANDBY_O;
  endproperty
  a_standby: assert property (p_standby)
    else $error("no standby entry");

  property p_wait_len;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    mode == LVSC_ACTIVE && next_mode == LVSC_STANDBY_WAIT
    && system_control_one[SYS1_STS_LO+:3] == STS_LONG
    |=> wait_cnt == 18'd131072;
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("wrong wait length");

  property p_osc;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    !system_control_two[SYS2_MA_LO+2] |=> OSC_CLK_SEL_O;
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator not selected");

  property p_mon_off;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    !voltage_monitor_control[CTRL_MON_EN] |-> !drop_evt && !lv_reset;
  endproperty
  a_mon_off: assert property (p_mon_off)
    else $error("detector active while off");

  property p_reset;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    !voltage_monitor_control[CTRL_RST_EN] |=> !LV_RESET_O;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset while disabled");

  property p_sticky;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
    voltage_monitor_status[STAT_DROP] && !wr_hit
    |=> voltage_monitor_status[STAT_DROP];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag lost");

  c_drop:    cover property (@(posedge REF_CLK_I) drop_evt);
  c_rise:    cover property (@(posedge REF_CLK_I) rise_evt);
  c_standby: cover property (@(posedge REF_CLK_I)
                             mode == LVSC_STANDBY);

endmodule
